// ---- inc/evt_pkg.sv ----
// event controller package: level numbering, register offsets, reset values, timing counts
// assumes a single 200 MHz core clock and a plain address/strobe register port
package evt_pkg;
   localparam int NUM_LEVELS = 16;               // priority levels 0..15
   localparam int LVL_EMU = 0;                   // emulation
   localparam int LVL_RST = 1;                   // reset event
   localparam int LVL_NMI = 2;                   // non-maskable
   localparam int LVL_EXC = 3;                   // exception
   localparam int LVL_RSVD = 4;                  // reserved, never fires
   localparam int LVL_HWERR = 5;                 // hardware error
   localparam int LVL_TMR = 6;                   // core timer
   localparam int LVL_GEN_LO = 7;                // first general level
   localparam int LVL_GEN_HI = 15;               // last general level
   localparam int NUM_GEN = 9;                   // general levels 7..15
   localparam int NUM_PERIPH = 7;                // router-fed levels 7..13
   localparam int NUM_SWI = 2;                   // software levels 14..15
   localparam int AW = 4;                        // register address width
   localparam logic [AW-1:0] ADR_LATCH = 4'h0;   // event_latch_bits
   localparam logic [AW-1:0] ADR_ENABLE = 4'h1;  // event_enable_bits
   localparam logic [AW-1:0] ADR_ACTIVE = 4'h2;  // event_active_bits
   localparam logic [AW-1:0] ADR_RETN = 4'h3;    // return: clear highest active
   localparam logic [AW-1:0] ADR_SWRAISE = 4'h4; // software raise of a level
   localparam logic [AW-1:0] ADR_MODE = 4'h5;    // operating mode (read)
   localparam logic [AW-1:0] ADR_RETADDR = 4'h8; // return address base, 8..
   localparam logic [AW-1:0] ADR_CURPC = 4'h6;   // current pc to save (write)
   localparam logic [15:0] ENABLE_RST = 16'h001F;// unmaskable classes enabled
   localparam logic [15:0] UNMASKABLE = 16'h000F;// emu, reset, nmi, exception
   localparam logic [15:0] RSVD_MASK = 16'h0010; // reserved level
   localparam int DET_CYCLES = 2;                // edge detection latency
   localparam int MIN_LAT_CYCLES = 3;            // edge to active minimum
   typedef enum logic [2:0] {
      MODE_USER = 3'b001,
      MODE_SUPV = 3'b010,
      MODE_EMUL = 3'b100
   } mode_t;
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

// ---- rtl/core_event_ctrl.sv ----
// core event controller: latches, masks, prioritises and nests sixteen event levels
// assumes synchronous inputs, a one-cycle register port and a core that acts on TAKE_O
// Overview of operation
// - nine general levels, seven through fifteen
// - levels 7-13 take router peripheral requests
// - fixed priority, level zero wins
// - per-class return address, one return operation for the highest active class
// - processor state pushed on entry
// - peripheral requests arrive only via router
// - user, supervisor or emulation mode
// - latch on rising edge, two-cycle detect
// - serviced only when enable bit set
// - active bit per class tracks nesting
// - active no sooner than three cycles
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module core_event_ctrl
#(
   parameter int ADDR_W = 32  // return address width
)(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic [evt_pkg::NUM_LEVELS-1:0] EVENT_I,  // raw event lines, 7..13 from router
   input wire evt_pkg::reg_req_t REG_I,                 // register port request
   output logic [31:0] RDATA_O,                         // read data, cycle after read
   output logic TAKE_O,                                 // one-cycle entry pulse
   output logic [3:0] TAKE_LVL_O,                       // level being entered
   output logic PUSH_O,                                 // push state on supervisor stack
   output logic [ADDR_W-1:0] PUSH_ADDR_O,               // saved return address
   output logic [2:0] MODE_O,                           // operating mode
   output logic [evt_pkg::NUM_LEVELS-1:0] ACTIVE_O      // active bits, router acknowledge
);
   import evt_pkg::*;

   logic [NUM_LEVELS-1:0] in_d1_r;     // input sample, first detect cycle
   logic [NUM_LEVELS-1:0] in_d2_r;     // input sample, second detect cycle
   logic [NUM_LEVELS-1:0] latch_r;     // event_latch_bits
   logic [NUM_LEVELS-1:0] enable_r;    // event_enable_bits
   logic [NUM_LEVELS-1:0] active_r;    // event_active_bits
   logic [NUM_LEVELS-1:0] rise;        // detected rising edges
   logic [NUM_LEVELS-1:0] cand;        // latched and enabled
   logic [ADDR_W-1:0] retaddr_r [NUM_LEVELS]; // return address per class
   logic [ADDR_W-1:0] curpc_r;         // pc handed in by the sequencer
   mode_t mode_r;                      // current mode
   logic take_nxt;                     // an event is accepted this cycle
   logic [3:0] take_lvl_nxt;           // its level
   logic [3:0] top_active;             // highest-priority active level
   logic any_active;                   // any level active
   logic ret_req;                      // return-from-event write
   logic [NUM_LEVELS-1:0] ret_clr;     // active bit released by a return

   // two-stage edge detection; stages only feed each other and the compare
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         in_d1_r <= '0;
         in_d2_r <= '0;
      end else begin
         in_d1_r <= EVENT_I;
         in_d2_r <= in_d1_r;
      end
   end
   assign rise = in_d1_r & ~in_d2_r & ~RSVD_MASK;

   // pick the highest active level, used for nesting and for returns
   always_comb begin
      top_active = 4'h0;
      any_active = 1'b0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
         if (active_r[i]) begin
            top_active = 4'(i);
            any_active = 1'b1;
         end
      end
   end

   // acceptance: lowest number wins and must beat every active level
   always_comb begin
      cand = latch_r & enable_r;
      take_nxt = 1'b0;
      take_lvl_nxt = 4'h0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
         if (cand[i]) begin
            take_nxt = 1'b1;
            take_lvl_nxt = 4'(i);
         end
      end
      // equal or lower priority waits for the return of the higher one
      if (any_active && take_lvl_nxt >= top_active) begin
         take_nxt = 1'b0;
      end
   end

   assign ret_req = REG_I.wr && REG_I.addr == ADR_RETN && any_active;
   assign ret_clr = ret_req ? (16'h0001 << top_active) : '0;

   // latch bits: set on edge, cleared on entry or by software while masked
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         latch_r <= '0;
      end else begin
         for (int i = 0; i < NUM_LEVELS; i++) begin
            if (rise[i]) begin
               latch_r[i] <= 1'b1;  // set wins over any clear
            end else if (REG_I.wr && REG_I.addr == ADR_SWRAISE && REG_I.wdata[i]
                         && i >= LVL_GEN_HI - NUM_SWI + 1) begin
               latch_r[i] <= 1'b1;  // a raise in the entry cycle is a new request
            end else if (take_nxt && take_lvl_nxt == 4'(i)) begin
               latch_r[i] <= 1'b0;
            end else if (REG_I.wr && REG_I.addr == ADR_LATCH && REG_I.wdata[i]
                         && !enable_r[i] && mode_r != MODE_USER) begin
               latch_r[i] <= 1'b0;  // cancel only while masked
            end
         end
      end
   end

   // enable bits: supervisor write, unmaskable classes stay enabled
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         enable_r <= ENABLE_RST & ~RSVD_MASK;
      end else if (REG_I.wr && REG_I.addr == ADR_ENABLE && mode_r != MODE_USER) begin
         enable_r <= (REG_I.wdata[NUM_LEVELS-1:0] | UNMASKABLE) & ~RSVD_MASK;
      end
   end

   // active bits: set on entry, cleared by the matching return
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         active_r <= '0;
      end else begin
         for (int i = 0; i < NUM_LEVELS; i++) begin
            if (take_nxt && take_lvl_nxt == 4'(i)) begin
               active_r[i] <= 1'b1;
            end else if (ret_clr[i]) begin
               active_r[i] <= 1'b0;
            end
         end
      end
   end

   // return address per class, captured from the current pc on entry
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         curpc_r <= '0;
         for (int i = 0; i < NUM_LEVELS; i++) begin
            retaddr_r[i] <= '0;
         end
      end else begin
         if (REG_I.wr && REG_I.addr == ADR_CURPC) begin
            curpc_r <= REG_I.wdata[ADDR_W-1:0];
         end
         if (take_nxt) begin
            retaddr_r[take_lvl_nxt] <= curpc_r;
         end
      end
   end

   // mode: emulation for level 0, supervisor inside a handler, else user
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_r <= MODE_SUPV;  // reset runs as supervisor
      end else if (take_nxt) begin
         mode_r <= (take_lvl_nxt == 4'(LVL_EMU)) ? MODE_EMUL : MODE_SUPV;
      end else if (ret_req) begin
         // leaving the last handler drops back to user
         mode_r <= ((active_r & ~ret_clr) == '0) ? MODE_USER :
                   ((active_r & ~ret_clr & 16'h0001) != '0) ? MODE_EMUL : MODE_SUPV;
      end
   end

   // entry outputs: pulse, level and the state push with its address
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         TAKE_O <= 1'b0;
         TAKE_LVL_O <= 4'h0;
         PUSH_O <= 1'b0;
         PUSH_ADDR_O <= '0;
      end else begin
         TAKE_O <= take_nxt;
         TAKE_LVL_O <= take_nxt ? take_lvl_nxt : TAKE_LVL_O;
         PUSH_O <= take_nxt;
         PUSH_ADDR_O <= take_nxt ? curpc_r : PUSH_ADDR_O;
      end
   end
   assign MODE_O = mode_r;
   assign ACTIVE_O = active_r;

   // register read, data valid the cycle after the strobe; user sees zero except the mode register
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= '0;
      end else if (REG_I.rd) begin
         RDATA_O <= '0;
         if (REG_I.addr == ADR_MODE) begin
            RDATA_O <= {29'h0, mode_r};
         end else if (mode_r != MODE_USER) begin
            case (REG_I.addr)
               ADR_LATCH: RDATA_O <= {16'h0, latch_r};
               ADR_ENABLE: RDATA_O <= {16'h0, enable_r};
               ADR_ACTIVE: RDATA_O <= {16'h0, active_r};
               default: begin
                  if (REG_I.addr >= ADR_RETADDR) begin
                     RDATA_O <= 32'(retaddr_r[{1'b0, REG_I.addr[2:0]}]);
                  end
               end
            endcase
         end
      end else begin
         RDATA_O <= '0;
      end
   end

   // checks beside the logic
   a_edge_latch: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      rise[7] |=> latch_r[7]) else $error("edge not latched");
   a_min_lat: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $rose(active_r[9]) |-> $past(in_d2_r[9], 1) || $past(latch_r[9], 1))
      else $error("active before detect");
   a_mask_block: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      take_nxt |-> enable_r[take_lvl_nxt]) else $error("masked taken");
   a_nest_prio: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      take_nxt && any_active |-> take_lvl_nxt < top_active)
      else $error("nesting order broken");
   a_latch_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      take_nxt && !rise[take_lvl_nxt] && !(REG_I.wr && REG_I.addr == ADR_SWRAISE)
      |=> !latch_r[$past(take_lvl_nxt)] && active_r[$past(take_lvl_nxt)])
      else $error("entry bookkeeping");
   a_push_entry: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      TAKE_O |-> PUSH_O && PUSH_ADDR_O == $past(curpc_r)) else $error("no push");
   a_rsvd_idle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !latch_r[LVL_RSVD] && !active_r[LVL_RSVD]) else $error("reserved fired");
   a_mode_handler: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      TAKE_O |-> mode_r != MODE_USER) else $error("user in handler");
   a_ret_addr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      take_nxt |=> retaddr_r[$past(take_lvl_nxt)] == $past(curpc_r))
      else $error("return address lost");
   c_take_gen: cover property (@(posedge CLK_I) disable iff (!RST_N_I) TAKE_O && TAKE_LVL_O == 4'd7);
   c_nested: cover property (@(posedge CLK_I) disable iff (!RST_N_I) active_r[7] && active_r[2]);
   c_return: cover property (@(posedge CLK_I) disable iff (!RST_N_I) ret_req);
   c_swi: cover property (@(posedge CLK_I) disable iff (!RST_N_I) TAKE_O && TAKE_LVL_O == 4'd15);
endmodule

// ---- dv/irq_router_model.sv ----
// system interrupt router model: turns peripheral request pulses into held level lines
// assumes the core's active bits come back as the acknowledge of each level
`timescale 1ns/1ps
module irq_router_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [6:0] req_i,  // one-cycle request pulses, one per router output
   input wire logic [15:0] ack_i, // core active bits
   output logic [6:0] lvl_o       // drives general levels 7..13 only, never 14..15
);
   // a request is held until the core reports that level active, so one pulse is one entry;
   // a level never acknowledged (masked) stays high and gives no further edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl_o <= 7'h00;
      end else begin
         lvl_o <= (lvl_o | req_i) & ~ack_i[13:7];
      end
   end
endmodule

// ---- dv/tb.sv ----
// testbench for the core event controller: masking, latency, nesting, return, modes
// assumes the router model feeds levels 7..13 and the bench drives events 0..6
`timescale 1ns/1ps
module tb;
   import evt_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] core_ev = 7'h00; // events 0..6 from the bench
   logic [6:0] per_req = 7'h00; // peripheral request pulses
   logic [6:0] per_lvl;
   reg_req_t rq = '0;
   logic [31:0] rdata, push_addr, v;
   logic take, push;
   logic [3:0] take_lvl;
   logic [2:0] mode;
   logic [15:0] active;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   always #2.5 clk = ~clk;
   irq_router_model router (.clk_i(clk), .rst_n_i(rst_n), .req_i(per_req), .ack_i(active),
      .lvl_o(per_lvl));
   core_event_ctrl uut (.CLK_I(clk), .RST_N_I(rst_n), .EVENT_I({2'b00, per_lvl, core_ev}),
      .REG_I(rq), .RDATA_O(rdata), .TAKE_O(take), .TAKE_LVL_O(take_lvl), .PUSH_O(push),
      .PUSH_ADDR_O(push_addr), .MODE_O(mode), .ACTIVE_O(active));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // register write: one strobe cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      rq.wr <= 1'b0;
   endtask
   // register read: data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      rq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      rq.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // bounded wait for a level to go active, counting edges
   task automatic wait_lvl(input int l, output int k);
      k = 0;
      while (active[l] !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   task automatic t_reset;
      rd(ADR_ENABLE, v);
      chk(v, 32'(ENABLE_RST & ~RSVD_MASK));
      chk(32'(mode), 32'(MODE_SUPV));
      chk(32'(active), 32'h0000_0000);
      $display("test reset done");
   endtask
   // timer and level 8 masked: latched but never serviced, then cancelled
   task automatic t_mask;
      wr(ADR_ENABLE, 32'h0000_c29f);
      wr(ADR_CURPC, 32'h1234_5678);
      core_ev[6] <= 1'b1;
      per_req <= 7'h02;
      @(posedge clk);
      per_req <= 7'h00;
      repeat (8) @(posedge clk);
      #1;
      chk(32'(active), 32'h0000_0000);
      rd(ADR_LATCH, v);
      chk(v, 32'h0000_0140);
      wr(ADR_LATCH, 32'h0000_0140);
      rd(ADR_LATCH, v);
      chk(v, 32'h0000_0000);
      core_ev[6] <= 1'b0;
      $display("test mask done");
   endtask
   task automatic t_nest;
      per_req <= 7'h01;
      @(posedge clk);
      per_req <= 7'h00;
      wait (per_lvl[0]);
      wait_lvl(7, n);
      chk(32'(n), 32'h0000_0003);
      chk({take, push, take_lvl}, {2'b11, 4'h7});
      chk(push_addr, 32'h1234_5678);
      @(posedge clk);
      #1;
      chk({take, push}, 2'b00);
      rd(ADR_LATCH, v);
      chk(v, 32'h0000_0000);
      // level 9 is a single pulse, so it enters once only after both returns
      per_req <= 7'h04;
      @(posedge clk);
      per_req <= 7'h00;
      repeat (5) @(posedge clk);
      #1;
      chk(32'(active), 32'h0000_0080);
      wr(ADR_CURPC, 32'hcafe_0002);
      core_ev[2] <= 1'b1;
      wait_lvl(2, n);
      chk(32'(take_lvl), 32'h0000_0002);
      chk(32'(active), 32'h0000_0084);
      core_ev[2] <= 1'b0;
      rd(ADR_RETADDR + 4'h2, v);
      chk(v, 32'hcafe_0002);
      wr(ADR_RETN, 32'h0000_0000);
      @(posedge clk);
      #1;
      chk(32'(active), 32'h0000_0080);
      wr(ADR_RETN, 32'h0000_0000);
      wait_lvl(9, n);
      chk(32'(take_lvl), 32'h0000_0009);
      chk(32'(active), 32'h0000_0200);
      wr(ADR_RETN, 32'h0000_0000);
      @(posedge clk);
      #1;
      chk(32'(active), 32'h0000_0000);
      chk(32'(mode), 32'(MODE_USER));
      rd(ADR_ENABLE, v);
      chk(v, 32'h0000_0000);
      $display("test nest done");
   endtask
   // software level raised from user mode enters in supervisor and returns to user
   task automatic t_swi;
      wr(ADR_SWRAISE, 32'h0000_8000);
      wait_lvl(15, n);
      chk(32'(take_lvl), 32'h0000_000f);
      chk(32'(mode), 32'(MODE_SUPV));
      wr(ADR_RETN, 32'h0000_0000);
      rd(ADR_MODE, v);
      chk(v, 32'(MODE_USER));
      // emulation outranks all; the reserved line is driven too and must never enter
      @(posedge clk);
      core_ev <= 7'h11;
      wait_lvl(0, n);
      chk(32'(mode), 32'(MODE_EMUL));
      chk(32'(take_lvl), 32'h0000_0000);
      repeat (3) @(posedge clk);
      #1;
      chk(32'(active), 32'h0000_0001);
      rd(ADR_MODE, v);
      chk(v, 32'(MODE_EMUL));
      core_ev <= 7'h00;
      wr(ADR_RETN, 32'h0000_0000);
      @(posedge clk);
      #1;
      chk(32'(active), 32'h0000_0000);
      chk(32'(mode), 32'(MODE_USER));
      $display("test swi done");
   endtask
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_mask();
      t_nest();
      t_swi();
      test_done();
   end
endmodule
